// ---- test/hpw_stage_model.sv ----
`timescale 1ns/10ps
module hpw_stage_model (
    // clock
    input  wire logic hclk,
    // overcurrent requests from the bench
    input  wire logic trip_a,
    input  wire logic trip_b,
    // open-drain fault lines with pull-ups
    output logic      fault_a_n,
    output logic      fault_b_n
);
    logic [1:0] pull_ff = 2'b00;

    always @(posedge hclk) begin
        pull_ff <= {trip_b, trip_a};
    end

    // a released line returns to its pull-up level
    assign fault_a_n = ~pull_ff[0];
    assign fault_b_n = ~pull_ff[1];
endmodule : hpw_stage_model

// ---- test/hpw_top_props.sv ----
`timescale 1ns/10ps
module hpw_chk
    import hpw_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // pins
    input wire logic        fault_a_n,
    input wire logic        fault_b_n,
    input wire logic        bridge_a_high,
    input wire logic        bridge_a_low,
    input wire logic        bridge_b_high,
    input wire logic        bridge_b_low,
    input wire logic        channel4_out,
    input wire logic        channel5_out,
    input wire logic        fault_irq,
    input wire logic [5:0]  pin_pwm_func
);
    logic        dp_ff;
    logic        dpw_ff;
    logic [7:0]  dpa_ff;
    logic [15:0] sh_ff;
    wire  [3:0]  br = {bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low};
    wire  [5:0]  all6 = {br, channel4_out, channel5_out};
    wire         m_on = sh_ff[HPW_B_MASTER_ON] & ~fault_irq;
    wire         hb = sh_ff[HPW_B_BRIDGE_SELECT] & ~sh_ff[HPW_B_HS_OFF];
    wire         drv = hb & sh_ff[HPW_B_DRIVE_ON] & m_on;
    wire         clr = dp_ff & dpw_ff & (dpa_ff == HPW_OFS_IRQ_CLR);

    // data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_ff  <= 1'b0;
            dpw_ff <= 1'b0;
            dpa_ff <= 8'h00;
        end else if (hready) begin
            dp_ff  <= hsel & htrans[1];
            dpw_ff <= hwrite;
            dpa_ff <= haddr[7:0];
        end
    end

    // shadow of the control register, master bit dropped while fault_irq is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_ff <= HPW_CTRL_RST;
        end else if (dp_ff && dpw_ff && dpa_ff == HPW_OFS_CTRL) begin
            sh_ff <= hwdata[15:0] & HPW_CTRL_MASK;
        end else if (fault_irq) begin
            sh_ff[HPW_B_MASTER_ON] <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_trip_low;
        sh_ff[HPW_B_FAULT_EN] && !(fault_a_n && fault_b_n);
    endsequence

    a_bus_okay: assert property (hreadyout && hresp == HPW_HRESP_OKAY)
        else $error("bus not ready or not okay");
    a_pin_func: assert property (pin_pwm_func == 6'h3f)
        else $error("pins left pwm function");
    a_reset_vals: assert property ($rose(hresetn) |-> all6 == 6'b101000)
        else $error("wrong outputs after reset");
    a_force_off: assert property ($past(sh_ff[1] && sh_ff[4]) |-> br == 4'b1010)
        else $error("force off not applied");
    a_drive_off: assert property ($past(hb && !sh_ff[9] && m_on) |-> br == 4'hf)
        else $error("drive off outputs not high");
    a_held_low: assert property ($past(drv && !sh_ff[5]) |->
        ($past(sh_ff[2]) ? br[1:0] == 2'b00 : br[3:2] == 2'b00))
        else $error("idle leg not low");
    a_held_high: assert property ($past(drv && sh_ff[5]) |->
        ($past(sh_ff[2]) ? br[3:2] == 2'b11 : br[1:0] == 2'b11))
        else $error("idle leg not high");
    a_master_off: assert property ($past(!m_on && !sh_ff[5] && !(sh_ff[1] && sh_ff[4]))
        |-> all6 == 6'h00)
        else $error("outputs active with master off");
    a_trip_irq: assert property (s_trip_low [*3] |=> fault_irq)
        else $error("trip did not raise interrupt");
    a_trip_gate: assert property ($rose(fault_irq) |-> $past(sh_ff[10]))
        else $error("interrupt with trip disabled");
    a_irq_clear: assert property (clr && !sh_ff[10] |=> !fault_irq)
        else $error("interrupt not cleared");
endmodule : hpw_chk

bind hpw_top hpw_chk u_hpw_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .fault_a_n, .fault_b_n, .bridge_a_high, .bridge_a_low,
    .bridge_b_high, .bridge_b_low, .channel4_out, .channel5_out, .fault_irq,
    .pin_pwm_func
);

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import hpw_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        ext_align_n = 1'b1;
    logic        trip_a = 1'b0;
    logic        trip_b = 1'b0;
    logic        hready, hreadyout, hresp, fault_a_n, fault_b_n, fault_irq;
    logic        bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low;
    logic        channel4_out, channel5_out;
    logic [31:0] hrdata, rd;
    logic [5:0]  pin_pwm_func;
    int          err_total = 0;
    int          n_checks = 0;
    int          n, d1;
    logic [15:0] ct [16] = '{16'h8013, 16'h0237, 16'h0003, 16'h0027, 16'h0203,
        16'h1203, 16'h0207, 16'h0a07, 16'h0223, 16'h0227, 16'h0021, 16'h2001,
        16'h1801, 16'h0000, 16'h0002, 16'h0201};
    logic [5:0]  ex [16] = '{6'h2a, 6'h29, 6'h3e, 6'h3d, 6'h0a, 6'h0e, 6'h22,
        6'h32, 6'h2d, 6'h39, 6'h15, 6'h2b, 6'h3e, 6'h00, 6'h00, 6'h2a};
    wire  [5:0]  outs = {bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low,
        channel4_out, channel5_out};

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    hpw_top u_hpw_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ext_align_n, .fault_a_n,
        .fault_b_n, .bridge_a_high, .bridge_a_low, .bridge_b_high, .bridge_b_low,
        .channel4_out, .channel5_out, .fault_irq, .pin_pwm_func);
    hpw_stage_model u_hpw_stage_model (.hclk, .trip_a, .trip_b, .fault_a_n,
        .fault_b_n);

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= HPW_HTRANS_NSEQ;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // length of one high pulse on the pair 0 high side
    task automatic hi_len(output int len);
        len = 0;
        while (bridge_a_high !== 1'b0) @(negedge hclk);
        while (bridge_a_high !== 1'b1) @(negedge hclk);
        while (bridge_a_high === 1'b1) begin
            @(negedge hclk);
            len++;
        end
    endtask : hi_len

    initial begin
        repeat (30000) @(posedge hclk);
        err_total++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("outs", 32'(outs), 32'h28);
        chk("func", 32'(pin_pwm_func), 32'h3f);
        bus(1'b0, HPW_OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h12);
        bus(1'b1, 8'h3c, 32'hffff);
        bus(1'b0, 8'h3c, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b0, HPW_OFS_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, HPW_OFS_CTRL, {16'h0, ct[i]});
            bus(1'b0, HPW_OFS_CTRL, 32'h0);
            chk("ctrl", rd, {16'h0, ct[i] & 16'h7fff});
            repeat (12) @(negedge hclk);
            chk("outs", 32'(outs), 32'(ex[i]));
        end
        bus(1'b1, HPW_OFS_PAIR0 + HPW_OFS_COM0, 32'h1);
        bus(1'b1, HPW_OFS_PAIR0 + HPW_OFS_COM1, 32'h0);
        bus(1'b1, HPW_OFS_PAIR0 + HPW_OFS_COM2, 32'h1);
        bus(1'b1, HPW_OFS_PAIR0 + HPW_OFS_LEN, 32'h1);
        bus(1'b0, HPW_OFS_PAIR0 + HPW_OFS_LEN, 32'h0);
        chk("len", rd, 32'h1);
        bus(1'b1, HPW_OFS_CTRL, 32'h1);
        n = 0;
        repeat (40) begin
            @(negedge hclk);
            if (bridge_a_high === 1'b1) n++;
        end
        chk("no reload", n, 40);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, HPW_OFS_CTRL, 32'h9 | 32'(c << 6));
            hi_len(n);
            hi_len(n);
            chk("high time", n, 2 << c);
        end
        bus(1'b1, HPW_OFS_CTRL, 32'h40c9);
        for (int k = 0; k < 2; k++) begin
            @(posedge hclk);
            ext_align_n <= 1'b0;
            n = 0;
            repeat (2) begin
                do begin @(negedge hclk); n++; end while (bridge_a_high !== 1'b0);
                do begin @(negedge hclk); n++; end while (bridge_a_high !== 1'b1);
            end
            ext_align_n <= 1'b1;
            if (k == 0) d1 = n % 32;
            repeat (211 - n) @(negedge hclk);
        end
        chk("align phase", n % 32, d1);
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, HPW_OFS_CTRL, 32'h401);
            trip_a <= (p == 0);
            trip_b <= (p == 1);
            n = 0;
            while (fault_irq !== 1'b1 && n < 10) begin
                @(negedge hclk);
                n++;
            end
            chk("irq", 32'(fault_irq), 32'h1);
            bus(1'b0, HPW_OFS_STATUS, 32'h0);
            chk("status", rd, 32'h3);
            bus(1'b0, HPW_OFS_CTRL, 32'h0);
            chk("ctrl", rd, 32'h400);
            chk("outs", 32'(outs), 32'h0);
            trip_a <= 1'b0;
            trip_b <= 1'b0;
            bus(1'b1, HPW_OFS_CTRL, 32'h0);
            bus(1'b1, HPW_OFS_IRQ_CLR, p ? 32'hffffffff : 32'h0);
            bus(1'b0, HPW_OFS_STATUS, 32'h0);
            chk("status", rd, 32'h0);
        end
        bus(1'b1, HPW_OFS_CTRL, 32'h1);
        trip_a <= 1'b1;
        repeat (10) @(negedge hclk);
        chk("irq", 32'(fault_irq), 32'h0);
        trip_a <= 1'b0;
        end_sim();
    end
endmodule : testbench

// ---- verilog/hpw_pair.sv ----
`timescale 1ns/10ps
module hpw_pair
    import hpw_pkg::*;
(
    // clock and reset
    input  wire logic      hclk,
    input  wire logic      hresetn,
    // control
    input  wire logic      tick,
    input  wire logic      sync_clr,
    input  wire logic      reload_req,
    input  wire hpw_cmp_s  cmp_prog,
    // waveforms
    output hpw_wave_s      wave
);

    logic [15:0] timer_ff;
    hpw_cmp_s    cmp_int_ff;
    logic        hs_ff;
    logic        ls_ff;
    logic        hs_fall;

    assign wave.hs = hs_ff;
    assign wave.ls = ls_ff;
    // first compare wins on equal values, so no fall then
    assign hs_fall = hs_ff && (timer_ff == cmp_int_ff.com1) && (timer_ff != cmp_int_ff.com0);

    // timer counts 0..len then wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_ff <= HPW_TMR_ZERO;
        end else if (sync_clr) begin
            timer_ff <= HPW_TMR_ZERO;
        end else if (tick) begin
            if (timer_ff >= cmp_prog.len) begin
                timer_ff <= HPW_TMR_ZERO;
            end else begin
                timer_ff <= timer_ff + 16'h0001;
            end
        end
    end

    // internal compare copy taken on the 0 to 1 step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_int_ff <= '0;
        end else if (tick && !sync_clr && reload_req && timer_ff == HPW_TMR_ZERO
                     && cmp_prog.len != HPW_TMR_ZERO) begin
            cmp_int_ff <= cmp_prog;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_ff <= 1'b0;
        end else if (tick) begin
            if (timer_ff == cmp_int_ff.com0) begin
                hs_ff <= 1'b1;
            end else if (timer_ff == cmp_int_ff.com1) begin
                hs_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_ff <= 1'b0;
        end else if (tick) begin
            if (timer_ff == cmp_int_ff.com2 || hs_fall) begin
                ls_ff <= 1'b0;
            end else if (timer_ff == cmp_prog.len) begin
                ls_ff <= 1'b1;
            end
        end
    end

endmodule : hpw_pair

// ---- verilog/hpw_pkg.sv ----
package hpw_pkg;

    // register byte offsets
    localparam logic [7:0] HPW_OFS_CTRL     = 8'h00;
    localparam logic [7:0] HPW_OFS_PAIR0    = 8'h04;
    localparam logic [7:0] HPW_PAIR_STRIDE  = 8'h10;
    localparam logic [7:0] HPW_OFS_COM0     = 8'h00;
    localparam logic [7:0] HPW_OFS_COM1     = 8'h04;
    localparam logic [7:0] HPW_OFS_COM2     = 8'h08;
    localparam logic [7:0] HPW_OFS_LEN      = 8'h0c;
    localparam logic [7:0] HPW_OFS_IRQ_CLR  = 8'h34;
    localparam logic [7:0] HPW_OFS_STATUS   = 8'h38;

    // control register fields
    localparam int HPW_B_SYNC_EN    = 14;
    localparam int HPW_B_CH5_INV    = 13;
    localparam int HPW_B_BL_INV     = 12;
    localparam int HPW_B_AL_INV     = 11;
    localparam int HPW_B_FAULT_EN   = 10;
    localparam int HPW_B_DRIVE_ON   = 9;
    localparam int HPW_B_PRESC_HI   = 8;
    localparam int HPW_B_PRESC_LO   = 6;
    localparam int HPW_B_ALL_INV    = 5;
    localparam int HPW_B_HS_OFF     = 4;
    localparam int HPW_B_RELOAD     = 3;
    localparam int HPW_B_DIR        = 2;
    localparam int HPW_B_BRIDGE_SELECT      = 1;
    localparam int HPW_B_MASTER_ON  = 0;

    // status register fields
    localparam int HPW_B_ST_IRQ     = 0;
    localparam int HPW_B_ST_TRIP    = 1;

    // values after reset
    localparam logic [15:0] HPW_CTRL_RST    = 16'h0012;
    localparam logic [15:0] HPW_CTRL_MASK   = 16'h7fff;
    localparam logic [15:0] HPW_CMP_RST     = 16'h0000;
    localparam logic [7:0]  HPW_DIV_RST     = 8'h00;
    localparam int          HPW_NUM_PAIRS   = 3;

    // timer compare points
    localparam logic [15:0] HPW_TMR_ZERO    = 16'h0000;

    // ahb encodings
    localparam logic [1:0]  HPW_HTRANS_NSEQ = 2'h2;
    localparam logic        HPW_HRESP_OKAY  = 1'b0;

    typedef struct packed {
        logic [15:0] com0;
        logic [15:0] com1;
        logic [15:0] com2;
        logic [15:0] len;
    } hpw_cmp_s;

    typedef struct packed {
        logic hs;
        logic ls;
    } hpw_wave_s;

endpackage : hpw_pkg

// ---- verilog/hpw_top.sv ----
// Operation
// - with sync enable set, align pin falling edge resets all PWM counters three clock edges after the pin is sampled low.
// - bits 13, 12, 11 invert channel5_out, bridge_b_low, bridge_a_low.
// - fault enable set and either fault pin low clears master on, raises interrupt.
// - in bridge mode without force-off, drive-on enables or disables bridge outputs.
// - prescale field 8:6 divides core clock by 2 up to 256.
// - all-output invert flips every PWM output in standard mode, only channel4_out and channel5_out in bridge mode.
// - in bridge mode, force-off drives both highs high and both lows low, overriding all else.
// - reload request copies compare values when timer steps from 0x00 to 0x01.
// - direction picks which bridge leg carries the waveforms.
// - bridge select places the outputs in H-bridge mode, else standard mode.
// - master on enables all outputs; clear disables them all except where bridge force-off drives them.
// - bridge mode, drive and force-off clear: all four bridge outputs high.
// - drive on, no invert: direction 0 waveforms on leg b, 1 on leg a.
// - drive on, invert: direction 0 waveforms on leg a, b high; mirrored.
// - control register resets to 0x12.
// - PWM pins select their PWM function after reset.
// - high side rises at first compare, falls at second compare.
// - low side rises at period, falls at third compare or high-side fall.
// - any write to the interrupt clear register clears the fault interrupt, unless an enabled trip occurs in that cycle.
`timescale 1ns/10ps
module hpw_top
    import hpw_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // external pins
    input  wire logic        ext_align_n,
    input  wire logic        fault_a_n,
    input  wire logic        fault_b_n,
    // pwm outputs
    output logic             bridge_a_high,
    output logic             bridge_a_low,
    output logic             bridge_b_high,
    output logic             bridge_b_low,
    output logic             channel4_out,
    output logic             channel5_out,
    output logic             fault_irq,
    output logic [5:0]       pin_pwm_func
);

    logic [15:0] pwm_main_control_ff;
    hpw_cmp_s    cmp_ff [HPW_NUM_PAIRS];
    hpw_wave_s   wave   [HPW_NUM_PAIRS];
    logic        fault_irq_ff;
    logic [5:0]  pwm_out_ff;
    logic [5:0]  nxt_pwm_out;
    logic [5:0]  pin_func_ff;

    // ahb data phase state
    logic        dp_write_ff;
    logic [7:0]  dp_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;
    logic        hresp_ff;
    logic        addr_phase;
    logic [31:0] rd_mux;

    // synchronisers
    logic [2:0]  align_sync_ff;
    logic [1:0]  fault_a_sync_ff;
    logic [1:0]  fault_b_sync_ff;
    logic        align_fall;
    logic        sync_clr_ff;
    logic        trip;

    // prescaler
    logic [7:0]  div_cnt_ff;
    logic [7:0]  div_mask;
    logic        tick_ff;
    logic [2:0]  presc;

    // control fields
    logic        c_sync_en;
    logic        c_fault_en;
    logic        c_drive_on;
    logic        c_all_inv;
    logic        c_hs_off;
    logic        c_reload;
    logic        c_dir;
    logic        c_bridge_select;
    logic        c_master;

    assign c_sync_en  = pwm_main_control_ff[HPW_B_SYNC_EN];
    assign c_fault_en = pwm_main_control_ff[HPW_B_FAULT_EN];
    assign c_drive_on = pwm_main_control_ff[HPW_B_DRIVE_ON];
    assign c_all_inv  = pwm_main_control_ff[HPW_B_ALL_INV];
    assign c_hs_off   = pwm_main_control_ff[HPW_B_HS_OFF];
    assign c_reload   = pwm_main_control_ff[HPW_B_RELOAD];
    assign c_dir      = pwm_main_control_ff[HPW_B_DIR];
    assign c_bridge_select    = pwm_main_control_ff[HPW_B_BRIDGE_SELECT];
    assign c_master   = pwm_main_control_ff[HPW_B_MASTER_ON];
    assign presc      = pwm_main_control_ff[HPW_B_PRESC_HI:HPW_B_PRESC_LO];

    // ------------------------------------------------------------------
    // ahb-lite slave, zero wait states, always okay
    // ------------------------------------------------------------------
    assign addr_phase = hsel && hready && (htrans == HPW_HTRANS_NSEQ || htrans == 2'h3);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= 8'h00;
        end else if (hready) begin
            dp_write_ff <= addr_phase && hwrite;
            dp_addr_ff  <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HPW_HRESP_OKAY;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HPW_HRESP_OKAY;
        end
    end

    // read data is prepared at the address phase so it stands from a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr[7:0] == HPW_OFS_CTRL) begin
            rd_mux = {16'h0000, pwm_main_control_ff};
        end else if (haddr[7:0] == HPW_OFS_STATUS) begin
            rd_mux[HPW_B_ST_IRQ]  = fault_irq_ff;
            rd_mux[HPW_B_ST_TRIP] = trip;
        end
        for (int p = 0; p < HPW_NUM_PAIRS; p++) begin
            if (haddr[7:0] == HPW_OFS_PAIR0 + 8'(p) * HPW_PAIR_STRIDE + HPW_OFS_COM0) begin
                rd_mux = {16'h0000, cmp_ff[p].com0};
            end
            if (haddr[7:0] == HPW_OFS_PAIR0 + 8'(p) * HPW_PAIR_STRIDE + HPW_OFS_COM1) begin
                rd_mux = {16'h0000, cmp_ff[p].com1};
            end
            if (haddr[7:0] == HPW_OFS_PAIR0 + 8'(p) * HPW_PAIR_STRIDE + HPW_OFS_COM2) begin
                rd_mux = {16'h0000, cmp_ff[p].com2};
            end
            if (haddr[7:0] == HPW_OFS_PAIR0 + 8'(p) * HPW_PAIR_STRIDE + HPW_OFS_LEN) begin
                rd_mux = {16'h0000, cmp_ff[p].len};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // control register; fault trip clears master on
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_main_control_ff <= HPW_CTRL_RST;
        end else begin
            if (dp_write_ff && dp_addr_ff == HPW_OFS_CTRL) begin
                pwm_main_control_ff <= hwdata[15:0] & HPW_CTRL_MASK;
            end
            if (c_fault_en && trip) begin
                pwm_main_control_ff[HPW_B_MASTER_ON] <= 1'b0;
            end
        end
    end

    generate
        for (genvar g = 0; g < HPW_NUM_PAIRS; g++) begin : g_cmp
            localparam logic [7:0] BASE = HPW_OFS_PAIR0 + 8'(g) * HPW_PAIR_STRIDE;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cmp_ff[g] <= '{HPW_CMP_RST, HPW_CMP_RST, HPW_CMP_RST, HPW_CMP_RST};
                end else if (dp_write_ff) begin
                    if (dp_addr_ff == BASE + HPW_OFS_COM0) begin
                        cmp_ff[g].com0 <= hwdata[15:0];
                    end
                    if (dp_addr_ff == BASE + HPW_OFS_COM1) begin
                        cmp_ff[g].com1 <= hwdata[15:0];
                    end
                    if (dp_addr_ff == BASE + HPW_OFS_COM2) begin
                        cmp_ff[g].com2 <= hwdata[15:0];
                    end
                    if (dp_addr_ff == BASE + HPW_OFS_LEN) begin
                        cmp_ff[g].len <= hwdata[15:0];
                    end
                end
            end
            hpw_pair u_pair (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .tick       (tick_ff),
                .sync_clr   (sync_clr_ff),
                .reload_req (c_reload),
                .cmp_prog   (cmp_ff[g]),
                .wave       (wave[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // pin synchronisers, align edge and fault level
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            align_sync_ff   <= 3'h7;
            fault_a_sync_ff <= 2'h3;
            fault_b_sync_ff <= 2'h3;
        end else begin
            align_sync_ff   <= {align_sync_ff[1:0], ext_align_n};
            fault_a_sync_ff <= {fault_a_sync_ff[0], fault_a_n};
            fault_b_sync_ff <= {fault_b_sync_ff[0], fault_b_n};
        end
    end

    assign align_fall = align_sync_ff[2] && !align_sync_ff[1];
    assign trip       = !fault_a_sync_ff[1] || !fault_b_sync_ff[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_clr_ff <= 1'b0;
        end else begin
            sync_clr_ff <= c_sync_en && align_fall;
        end
    end

    // interrupt: a trip in the clearing cycle keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_irq_ff <= 1'b0;
        end else if (c_fault_en && trip) begin
            fault_irq_ff <= 1'b1;
        end else if (dp_write_ff && dp_addr_ff == HPW_OFS_IRQ_CLR) begin
            fault_irq_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // prescaler: one-cycle tick every 2^(presc+1) clocks
    // ------------------------------------------------------------------
    assign div_mask = 8'((9'h002 << presc) - 9'h001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_ff <= HPW_DIV_RST;
            tick_ff    <= 1'b0;
        end else if (sync_clr_ff) begin
            div_cnt_ff <= HPW_DIV_RST;
            tick_ff    <= 1'b0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
            tick_ff    <= (div_cnt_ff & div_mask) == div_mask;
        end
    end

    // ------------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------------
    always_comb begin
        nxt_pwm_out = {wave[2].ls, wave[2].hs, wave[1].ls, wave[1].hs,
                       wave[0].ls, wave[0].hs};
        if (c_bridge_select) begin
            nxt_pwm_out[5:4] = nxt_pwm_out[5:4] ^ {2{c_all_inv}};
            if (!c_drive_on) begin
                nxt_pwm_out[3:0] = 4'hf;
            end else if (!c_all_inv && !c_dir) begin
                nxt_pwm_out[3:0] = {nxt_pwm_out[1:0], 2'b00};
            end else if (!c_all_inv) begin
                nxt_pwm_out[3:0] = {2'b00, nxt_pwm_out[1:0]};
            end else if (!c_dir) begin
                nxt_pwm_out[3:0] = {2'b11, nxt_pwm_out[1:0]};
            end else begin
                nxt_pwm_out[3:0] = {nxt_pwm_out[1:0], 2'b11};
            end
        end else begin
            nxt_pwm_out = nxt_pwm_out ^ {6{c_all_inv}};
        end
        // per-pin inverts act on the pins, after the bridge mapping
        nxt_pwm_out[1] = nxt_pwm_out[1] ^ pwm_main_control_ff[HPW_B_AL_INV];
        nxt_pwm_out[3] = nxt_pwm_out[3] ^ pwm_main_control_ff[HPW_B_BL_INV];
        nxt_pwm_out[5] = nxt_pwm_out[5] ^ pwm_main_control_ff[HPW_B_CH5_INV];
        if (!c_master) begin
            nxt_pwm_out = 6'h00;
        end
        if (c_bridge_select && c_hs_off) begin
            nxt_pwm_out[3:0] = 4'b0101;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out_ff <= 6'h05;
        end else begin
            pwm_out_ff <= nxt_pwm_out;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_func_ff <= 6'h3f;
        end else begin
            pin_func_ff <= 6'h3f;
        end
    end

    assign bridge_a_high = pwm_out_ff[0];
    assign bridge_a_low  = pwm_out_ff[1];
    assign bridge_b_high = pwm_out_ff[2];
    assign bridge_b_low  = pwm_out_ff[3];
    assign channel4_out  = pwm_out_ff[4];
    assign channel5_out  = pwm_out_ff[5];
    assign fault_irq     = fault_irq_ff;
    assign pin_pwm_func  = pin_func_ff;
    assign hreadyout     = hreadyout_ff;
    assign hresp         = hresp_ff;
    assign hrdata        = hrdata_ff;

endmodule : hpw_top
